// ---- verilog/link_train_pkg.sv ----
// Constants for the link training, polarity and skip scheduling block.
// Assumes symbols are handled as decoded 8-bit characters plus a K flag.
`default_nettype none

package link_train_pkg;

	// Special and data characters (decoded form)
	localparam logic [7:0] SYM_COM   = 8'hBC;  // K28.5
	localparam logic [7:0] SYM_SKP   = 8'h3C;  // K28.1
	localparam logic [7:0] SYM_D10_2 = 8'h4A;
	localparam logic [7:0] SYM_D21_5 = 8'hB5;
	localparam logic [7:0] SYM_D5_2  = 8'h45;
	localparam logic [7:0] SYM_D0_0  = 8'h00;

	// Ordered set geometry
	localparam logic [4:0] TS_LAST    = 5'h0F;  // 16 symbols
	localparam logic [4:0] TSEQ_LAST  = 5'h1F;  // 32 symbols
	localparam logic [4:0] TS_COMS    = 5'h04;
	localparam logic [4:0] TS_CFG_POS = 5'h05;
	localparam int unsigned TSEQ_REPS_DEF = 65536;

	// Skip scheduling: one set per 354 symbols, at most four outstanding
	localparam logic [10:0] SKP_INTERVAL = 11'h162;  // 354
	localparam logic [10:0] SKP_DOUBLE   = 11'h2C4;  // 708
	localparam logic [10:0] Y_MAX        = 11'h6E9;  // 4*354+353

	// Link configuration symbol bits
	localparam int unsigned CFG_RESET    = 0;
	localparam int unsigned CFG_LOOPBACK = 2;
	localparam int unsigned CFG_NOSCR    = 3;
	localparam logic [7:0]  CFG_TX_MASK  = 8'h0C;  // bits 0,1,4-7 sent as 0

	// Register map (byte addresses)
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam int unsigned CTRL_EN    = 0;
	localparam int unsigned CTRL_TS2   = 1;
	localparam int unsigned CTRL_TSEQ  = 2;
	localparam int unsigned CTRL_DEFER = 3;
	localparam int unsigned CTRL_RXSEQ = 4;
	localparam int unsigned CTRL_CFG   = 8;

	// Elasticity buffer thresholds (16 entries, centre 8)
	localparam logic [4:0] EB_HI = 5'h0C;
	localparam logic [4:0] EB_LO = 5'h04;

	// Fixed data part of the equaliser training set, symbols 1..15
	function automatic logic [7:0] tseq_sym(input logic [4:0] idx);
		unique case (idx)
			5'h01: tseq_sym = 8'hFF;
			5'h02: tseq_sym = 8'h17;
			5'h03: tseq_sym = 8'hC0;
			5'h04: tseq_sym = 8'h14;
			5'h05: tseq_sym = 8'hB2;
			5'h06: tseq_sym = 8'hE7;
			5'h07: tseq_sym = 8'h02;
			5'h08: tseq_sym = 8'h82;
			5'h09: tseq_sym = 8'h72;
			5'h0A: tseq_sym = 8'h6E;
			5'h0B: tseq_sym = 8'h28;
			5'h0C: tseq_sym = 8'hA6;
			5'h0D: tseq_sym = 8'hBE;
			5'h0E: tseq_sym = 8'h6D;
			5'h0F: tseq_sym = 8'hBF;
			default: tseq_sym = SYM_D10_2;
		endcase
	endfunction : tseq_sym

endpackage : link_train_pkg

`default_nettype wire

// ---- verilog/link_train_phy.sv ----
// Training set generation and recognition, polarity detection, transmit
// skip scheduling and receive elasticity buffer for one serial link port.
// Assumes an external 8b/10b codec, scrambler and training state machine.
`default_nettype none

// Notes on behaviour
// R1 - Training symbols go through the encoder and bypass the scrambler.
// R2 - Skip sets never interrupt a training set, only before or after.
// R3 - Training sets follow back to back, only skip sets between them.
// R4 - No skip sets during the equaliser training period.
// R5 - Equaliser set: COM, fifteen fixed bytes, sixteen D10.2 symbols.
// R6 - Equaliser set repeats back to back for 65536 repetitions.
// R7 - TS1/TS2: four COM, D0.0, config symbol, ten identifier symbols.
// R8 - Config bit 0 is reset, host only; bits 1 and 4-7 sent zero.
// R9 - Received config bit 2 puts the port into digital loopback.
// R10 - Received config bit 3 disables scrambling.
// R11 - Bits 0 and 2 never sent together; receiver ignores such symbol.
// R12 - D21.5 instead of D10.2 during equaliser training means invert.
// R13 - Without equaliser use, polarity is judged from TS1 identifiers.
// R14 - A skip set is exactly two consecutive K28.1 symbols.
// R15 - Skip sets average one per 354 symbols, never inside a packet.
// R16 - At most four skip sets may be held back.
// R17 - Receive buffer absorbs eight symbols by dropping or adding skips.
// R18 - Count of symbols since last skip clears on polling entry.
// R19 - After each set or unit insert count/354 skip sets, nowhere else.
// R20 - During training skip insertion may wait until two are due.
// R21 - The remainder of count/354 carries into the next schedule.
// R22 - Skip sets do not break a run of consecutive training sets.
// R23 - COM is K28.5, skip is K28.1, both sent as K symbols.
// R24 - Each inserted skip set takes 354 off the running count.
module link_train_phy
	import link_train_pkg::*;
#(
	parameter int unsigned TSEQ_REPS = TSEQ_REPS_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic        cyc,
	input  wire logic        stb,
	input  wire logic        we,
	input  wire logic [3:0]  adr,
	input  wire logic [3:0]  sel,
	input  wire logic [31:0] dat_w,
	output logic      [31:0] dat_r,
	output logic             ack,
	// Training state machine hooks
	input  wire logic        polling_entry,
	// Packet / logical idle symbol source
	input  wire logic [7:0]  pkt_sym,
	input  wire logic        pkt_k,
	input  wire logic        pkt_last,
	input  wire logic        pkt_valid,
	output logic             pkt_ready,
	// Transmit symbols towards scrambler and encoder
	output logic [7:0]       tx_sym,
	output logic             tx_k,
	output logic             tx_no_scramble,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// Receive decoded symbols with recovered clock
	input  wire logic        rx_clk,
	input  wire logic [7:0]  rx_sym,
	input  wire logic        rx_k,
	output logic             rx_invert,
	output logic             rx_loopback,
	output logic             rx_scr_disable,
	output logic             rx_reset_req,
	// Receive symbols after the elasticity buffer
	output logic [7:0]       rx_out_sym,
	output logic             rx_out_k,
	output logic             rx_out_valid,
	input  wire logic        rx_out_ready
);

	typedef enum logic [1:0] {TX_IDLE, TX_SET, TX_SKP, TX_PKT} tx_state_e;

	logic [31:0] ctrl_q;
	tx_state_e   state_q, state_d;
	logic [4:0]  idx_q, idx_d;
	logic [16:0] rep_q, rep_d;
	logic        tseq_done_q, tseq_done_d;
	logic        skp2_q, skp2_d;
	logic        ts2_q;
	logic [10:0] y_q;
	logic [7:0]  nx_sym;
	logic        nx_k, nx_byp, nx_val, nx_skp, take_pkt;
	logic        tx_adv, set_tseq, train_en;
	logic [4:0]  set_last;
	logic [7:0]  cfg_tx;
	logic        skp_due;

	assign train_en = ctrl_q[CTRL_EN];
	assign set_tseq = ctrl_q[CTRL_TSEQ] && !tseq_done_q;
	assign set_last = set_tseq ? TSEQ_LAST : TS_LAST;
	// Device never requests a reset, nor loopback together with it
	assign cfg_tx = ctrl_q[CTRL_CFG +: 8] & CFG_TX_MASK;  // [R8] [R11]
	// Deferral lets two sets go out together while training
	assign skp_due = (train_en && ctrl_q[CTRL_DEFER]) ?
		(y_q >= SKP_DOUBLE) : (y_q >= SKP_INTERVAL);  // [R19] [R20]
	assign tx_adv = tx_ready || !tx_valid;

	// Next symbol and sequencer state
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		rep_d = rep_q;
		tseq_done_d = tseq_done_q;
		skp2_d = skp2_q;
		nx_sym = SYM_D0_0;
		nx_k = 1'b0;
		nx_byp = 1'b0;
		nx_val = 1'b0;
		nx_skp = 1'b0;
		take_pkt = 1'b0;
		unique case (state_q)
			TX_IDLE, TX_SET: begin
				if (state_q == TX_SET || train_en) begin
					nx_val = 1'b1;
					nx_byp = 1'b1;  // [R1]
					if (set_tseq) begin
						nx_k = (idx_q == 5'h00);
						nx_sym = nx_k ? SYM_COM : tseq_sym(idx_q);  // [R5]
					end else if (idx_q < TS_COMS) begin
						nx_k = 1'b1;
						nx_sym = SYM_COM;  // [R7] [R23]
					end else if (idx_q == TS_COMS) begin
						nx_sym = SYM_D0_0;
					end else if (idx_q == TS_CFG_POS) begin
						nx_sym = cfg_tx;
					end else begin
						// Kind is fixed at symbol 0 so no set mixes ids
						nx_sym = ts2_q ? SYM_D5_2 : SYM_D10_2;  // [R3]
					end
					state_d = TX_SET;
					idx_d = idx_q + 5'h01;
					if (idx_q == set_last) begin
						idx_d = 5'h00;
						if (set_tseq) begin
							// Equaliser sets run back to back, no skips
							rep_d = rep_q + 17'h00001;  // [R4] [R6]
							if (rep_q == 17'(TSEQ_REPS - 1)) begin
								tseq_done_d = 1'b1;
								rep_d = 17'h00000;
							end
						end else if (skp_due) begin
							state_d = TX_SKP;  // [R2] [R3]
						end else if (!train_en) begin
							state_d = TX_IDLE;
						end
					end
				end else if (pkt_valid) begin
					state_d = TX_PKT;
				end
			end
			TX_PKT: begin
				nx_val = pkt_valid;
				nx_sym = pkt_sym;
				nx_k = pkt_k;
				take_pkt = 1'b1;
				if (pkt_valid && pkt_last) begin
					// Skips only at the end of a unit, never inside
					state_d = skp_due ? TX_SKP : TX_IDLE;  // [R15] [R19]
				end
			end
			TX_SKP: begin
				nx_val = 1'b1;
				nx_k = 1'b1;
				nx_sym = SYM_SKP;  // [R14] [R23]
				nx_skp = 1'b1;
				skp2_d = !skp2_q;
				// Keep going while a whole further interval is owed
				if (skp2_q && y_q < SKP_DOUBLE) begin
					state_d = (train_en || set_tseq) ? TX_SET : TX_IDLE;
				end
			end
			default: state_d = TX_IDLE;
		endcase
	end

	assign pkt_ready = tx_adv && take_pkt;

	// Sequencer registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !train_en && !ctrl_q[CTRL_TSEQ]) begin
			tseq_done_q <= 1'b0;
		end else if (tx_adv) begin
			tseq_done_q <= tseq_done_d;
		end
		if (sys_rst) begin
			state_q <= TX_IDLE;
			idx_q <= 5'h00;
			rep_q <= 17'h00000;
			skp2_q <= 1'b0;
			ts2_q <= 1'b0;
		end else if (tx_adv) begin
			if (idx_q == 5'h00) begin
				ts2_q <= ctrl_q[CTRL_TS2];
			end
			state_q <= state_d;
			idx_q <= idx_d;
			rep_q <= rep_d;
			skp2_q <= skp2_d;
		end
	end

	// Transmit output stage
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_sym <= 8'h00;
			tx_k <= 1'b0;
			tx_no_scramble <= 1'b0;
			tx_valid <= 1'b0;
		end else if (tx_adv) begin
			tx_sym <= nx_sym;
			tx_k <= nx_k;
			tx_no_scramble <= nx_byp;
			tx_valid <= nx_val;
		end
	end

	// Symbols since the last skip; saturation caps the backlog at four
	always_ff @(posedge ref_clk) begin
		if (sys_rst || polling_entry) begin
			y_q <= 11'h000;  // [R18]
		end else if (tx_adv && nx_skp && skp2_q) begin
			y_q <= y_q - SKP_INTERVAL;  // [R21] [R24]
		end else if (tx_adv && nx_val && !nx_skp && !set_tseq
				&& y_q != Y_MAX) begin
			y_q <= y_q + 11'h001;  // [R16]
		end
	end

	// Receive clock and data pass three flops; an edge needs s2 == s3
	logic [2:0] rclk_s;
	logic       rclk_lvl_q, rx_edge;
	logic [8:0] rxd_s1, rxd_s2, rxd_s3;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rclk_s <= 3'h0;
			rclk_lvl_q <= 1'b0;
			rxd_s1 <= 9'h000;
			rxd_s2 <= 9'h000;
			rxd_s3 <= 9'h000;
		end else begin
			rclk_s <= {rclk_s[1:0], rx_clk};
			rxd_s1 <= {rx_k, rx_sym};
			rxd_s2 <= rxd_s1;
			rxd_s3 <= rxd_s2;
			if (rclk_s[1] == rclk_s[2]) begin
				rclk_lvl_q <= rclk_s[2];
			end
		end
	end
	assign rx_edge = (rclk_s[1] == rclk_s[2]) && rclk_s[2] && !rclk_lvl_q;

	// Ordered set recognition on each received symbol
	logic [4:0] pos_q;
	logic [7:0] cfg_rx_q;
	logic       id1_q, id2_q, idinv_q, last_ts2_q;
	logic [3:0] run_q;
	logic       rk, is_com, is_skp;
	logic [7:0] rs;
	assign rk = rxd_s3[8];
	assign rs = rxd_s3[7:0];
	assign is_com = rk && rs == SYM_COM;
	assign is_skp = rk && rs == SYM_SKP;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pos_q <= 5'h00;
			cfg_rx_q <= 8'h00;
			id1_q <= 1'b0;
			id2_q <= 1'b0;
			idinv_q <= 1'b0;
			last_ts2_q <= 1'b0;
			run_q <= 4'h0;
		end else if (rx_edge && !is_skp) begin  // [R22]
			if (is_com) begin
				pos_q <= (pos_q < TS_COMS) ? pos_q + 5'h01 : 5'h01;
				{id1_q, id2_q, idinv_q} <= 3'b111;
			end else if (pos_q >= TS_COMS && pos_q <= TS_LAST) begin
				pos_q <= (pos_q == TS_LAST) ? 5'h00 : pos_q + 5'h01;
				if (pos_q == TS_CFG_POS) begin
					cfg_rx_q <= rs;
				end else if (pos_q > TS_CFG_POS) begin
					id1_q <= id1_q && rs == SYM_D10_2;
					id2_q <= id2_q && rs == SYM_D5_2;
					idinv_q <= idinv_q && rs == SYM_D21_5;
				end
				if (pos_q == TS_LAST) begin
					if ((id1_q && rs == SYM_D10_2)
							|| (id2_q && rs == SYM_D5_2)) begin
						last_ts2_q <= id2_q;
						if (last_ts2_q != id2_q) begin
							run_q <= 4'h1;
						end else if (run_q != 4'hF) begin
							run_q <= run_q + 4'h1;
						end
					end else begin
						run_q <= 4'h0;
					end
				end
			end else begin
				pos_q <= 5'h00;
				run_q <= (pos_q == 5'h00) ? run_q : 4'h0;
			end
		end
	end

	// Training control bits from a complete set
	logic ts_done, cfg_ok;
	assign ts_done = rx_edge && !rk && pos_q == TS_LAST
		&& ((id1_q && rs == SYM_D10_2) || (id2_q && rs == SYM_D5_2));
	assign cfg_ok = !(cfg_rx_q[CFG_RESET] && cfg_rx_q[CFG_LOOPBACK]);
	always_ff @(posedge ref_clk) begin
		if (sys_rst || polling_entry) begin
			rx_loopback <= 1'b0;
			rx_scr_disable <= 1'b0;
			rx_reset_req <= 1'b0;
		end else if (ts_done && cfg_ok) begin  // [R11]
			rx_loopback <= cfg_rx_q[CFG_LOOPBACK];  // [R9]
			rx_scr_disable <= cfg_rx_q[CFG_NOSCR];  // [R10]
			rx_reset_req <= cfg_rx_q[CFG_RESET];
		end
	end

	// Polarity is set once per training attempt; inverted data then agrees
	always_ff @(posedge ref_clk) begin
		if (sys_rst || polling_entry) begin
			rx_invert <= 1'b0;
		end else if (rx_edge && !rk && rs == SYM_D21_5) begin
			if (ctrl_q[CTRL_RXSEQ]) begin
				rx_invert <= 1'b1;  // [R12]
			end else if (pos_q == TS_LAST && idinv_q) begin
				rx_invert <= 1'b1;  // [R13]
			end
		end
	end

	// Elasticity buffer: flops indexed by pointer, sixteen entries
	logic [8:0] eb_mem [16];
	logic [4:0] wr_q, rd_q, fill;
	logic       eb_pop, eb_drop, eb_dup, out_load;
	logic [8:0] head;
	assign fill = wr_q - rd_q;
	assign head = eb_mem[rd_q[3:0]];
	assign out_load = !rx_out_valid || rx_out_ready;
	// Skips are left alone during equaliser training
	assign eb_drop = fill > EB_HI && head == {1'b1, SYM_SKP}
		&& !ctrl_q[CTRL_RXSEQ];  // [R17]
	assign eb_dup = fill < EB_LO && head == {1'b1, SYM_SKP}
		&& !ctrl_q[CTRL_RXSEQ];  // [R17]
	assign eb_pop = fill != 5'h00 && (eb_drop || (out_load && !eb_dup));
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_q <= 5'h00;
			rd_q <= 5'h00;
		end else begin
			if (rx_edge && fill != 5'h10) begin
				eb_mem[wr_q[3:0]] <= rxd_s3;
				wr_q <= wr_q + 5'h01;
			end
			if (eb_pop) begin
				rd_q <= rd_q + 5'h01;
			end
		end
	end

	// Registered buffer output; a duplicated skip is shown without popping
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_out_valid <= 1'b0;
			rx_out_sym <= 8'h00;
			rx_out_k <= 1'b0;
		end else if (out_load) begin
			rx_out_valid <= fill != 5'h00 && !eb_drop;
			{rx_out_k, rx_out_sym} <= head;
		end
	end

	// Wishbone slave: one wait state, ack for one cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack <= 1'b0;
			dat_r <= 32'h0000_0000;
			ctrl_q <= CTRL_RST;
		end else begin
			ack <= cyc && stb && !ack;
			if (cyc && stb && !ack && we && adr == REG_CTRL) begin
				for (int i = 0; i < 4; i++) begin
					if (sel[i]) begin
						ctrl_q[i*8 +: 8] <= dat_w[i*8 +: 8];
					end
				end
			end
			unique case (adr)
				REG_CTRL:   dat_r <= ctrl_q;
				REG_STATUS: dat_r <= {18'h00000, fill, run_q,
					tseq_done_q, rx_reset_req, rx_scr_disable,
					rx_loopback, rx_invert};
				default:    dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// Checks
	sequence skp_first_s;
		tx_adv && nx_skp && !skp2_q;
	endsequence
	sequence skp_second_s;
		nx_skp && skp2_q;
	endsequence
	a_skp_pair_second: assert property (@(posedge ref_clk) disable iff
		(sys_rst) skp_first_s |=> skp_second_s)  // [R14]
		else $error("skip set not two symbols");
	a_no_skip_tseq: assert property (@(posedge ref_clk) disable iff
		(sys_rst) set_tseq && state_q == TX_SET |-> !nx_skp)  // [R4]
		else $error("skip during equaliser training");
	a_skip_after_set: assert property (@(posedge ref_clk) disable iff
		(sys_rst) $rose(state_q == TX_SKP) |-> $past(idx_q) == set_last
		|| $past(state_q) == TX_PKT)  // [R2]
		else $error("skip inserted inside a set");
	a_cfg_tx_clean: assert property (@(posedge ref_clk) disable iff
		(sys_rst) (cfg_tx & ~CFG_TX_MASK) == 8'h00)  // [R8]
		else $error("reserved config bits sent");
	a_count_bound: assert property (@(posedge ref_clk) disable iff
		(sys_rst) y_q <= Y_MAX)  // [R16]
		else $error("skip backlog above four");
	a_count_clear: assert property (@(posedge ref_clk) disable iff
		(sys_rst) polling_entry |=> y_q == 11'h000)  // [R18]
		else $error("symbol count not cleared");
	a_ignore_bad_cfg: assert property (@(posedge ref_clk) disable iff
		(sys_rst || polling_entry) ts_done && !cfg_ok
		|=> $stable(rx_loopback))  // [R11]
		else $error("bad config symbol obeyed");
	a_train_bypass: assert property (@(posedge ref_clk) disable iff
		(sys_rst) state_q == TX_SET && tx_adv |=> tx_no_scramble)  // [R1]
		else $error("training symbol scrambled");
	a_ack_single: assert property (@(posedge ref_clk) disable iff
		(sys_rst) ack |=> !ack)
		else $error("ack held two cycles");

endmodule : link_train_phy

`default_nettype wire

// ---- bench/link_partner.sv ----
// Remote port model: sends training sets over the link and stalls tx_ready.
// Assumes the block samples rx_clk with its own clock at eight times rate.
`default_nettype none

module link_partner
	import link_train_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       slow,
	output var  logic       tx_ready,
	output var  logic       rx_clk,
	output var  logic [7:0] rx_sym,
	output var  logic       rx_k
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [1:0] ph_q = 2'b00;

	// Idle link: clock stands still, data line low
	initial begin
		rx_clk = 1'b0;
		rx_sym = 8'h00;
		rx_k = 1'b0;
		tx_ready = 1'b0;
	end

	// Stall one cycle in four while slow, so the sender must hold symbols
	always @(posedge ref_clk) begin
		ph_q <= ph_q + 2'b01;
		tx_ready <= !(slow && ph_q == 2'b11);
	end

	// One symbol per 80 ns link period, stable across the whole period
	task automatic put(input logic [7:0] s, input logic k);
		rx_sym = s;
		rx_k = k;
		#40 rx_clk = 1'b1;
		#40 rx_clk = 1'b0;
	endtask : put

	// Unscrambled set, then a skip pair that must not break the run
	task automatic send_set(input logic [7:0] id, cfg);
		#3;
		for (int i = 0; i < 16; i++) begin
			put(i < 4 ? SYM_COM : i == 4 ? SYM_D0_0 : i == 5 ? cfg : id,
				i < 4);
		end
		put(SYM_SKP, 1'b1);
		put(SYM_SKP, 1'b1);
		// Clock stops; the line must not keep showing the last symbol
		rx_sym = ~rx_sym;
		rx_k = ~rx_k;
	endtask : send_set

endmodule : link_partner

`default_nettype wire

// ---- bench/link_train_phy_tb.sv ----
// Bench for the link training block: bus, sets, skips, equaliser, receive.
// Assumes the partner model drives the link and stalls tx_ready.
`default_nettype none

module link_train_phy_tb
	import link_train_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic        w;
		logic [3:0]  a;
		logic [3:0]  s;
		logic [31:0] d;
		logic [31:0] e;
	} bus_row_s;

	localparam int unsigned REPS = 4;
	localparam logic [7:0] TSQ [15] = '{8'hFF, 8'h17, 8'hC0, 8'h14, 8'hB2,
		8'hE7, 8'h02, 8'h82, 8'h72, 8'h6E, 8'h28, 8'hA6, 8'hBE, 8'h6D, 8'hBF};
	localparam bus_row_s ROWS [9] = '{
		'{1'b0, REG_CTRL, 4'hF, 32'h0, 32'h0},
		'{1'b0, REG_STATUS, 4'hF, 32'h0, 32'h0},
		'{1'b0, 4'h8, 4'hF, 32'h0, 32'h0},
		'{1'b1, REG_CTRL, 4'hF, 32'h0C10, 32'h0},
		'{1'b0, REG_CTRL, 4'hF, 32'h0, 32'h0C10},
		'{1'b1, REG_CTRL, 4'h1, 32'hFFFF_FF00, 32'h0},
		'{1'b0, REG_CTRL, 4'hF, 32'h0, 32'h0C00},
		'{1'b1, REG_STATUS, 4'hF, 32'hFFFF_FFFF, 32'h0},
		'{1'b0, REG_STATUS, 4'hF, 32'h0, 32'h0}};

	logic        ref_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, polling_entry = 1'b0, slow = 1'b1;
	logic        rx_out_ready = 1'b1;
	logic [3:0]  adr = 4'h0, sel = 4'h0;
	logic [31:0] dat_w = 32'h0, dat_r, rd;
	logic        ack, pkt_ready, tx_k, tx_no_scramble, tx_valid, tx_ready;
	logic        rx_clk, rx_k, rx_invert, rx_loopback, rx_scr_disable;
	logic        rx_reset_req, rx_out_k, rx_out_valid;
	logic [7:0]  tx_sym, rx_sym, rx_out_sym, got;
	logic [9:0]  q [$];
	logic [9:0]  v;
	int          n_mismatch = 0, samples_checked = 0, com_seen = 0, extra;

	link_train_phy #(.TSEQ_REPS(REPS)) dut (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack),
		.polling_entry(polling_entry), .pkt_sym(8'h00), .pkt_k(1'b0),
		.pkt_last(1'b0), .pkt_valid(1'b0), .pkt_ready(pkt_ready),
		.tx_sym(tx_sym), .tx_k(tx_k), .tx_no_scramble(tx_no_scramble),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_clk(rx_clk),
		.rx_sym(rx_sym), .rx_k(rx_k), .rx_invert(rx_invert),
		.rx_loopback(rx_loopback), .rx_scr_disable(rx_scr_disable),
		.rx_reset_req(rx_reset_req), .rx_out_sym(rx_out_sym),
		.rx_out_k(rx_out_k), .rx_out_valid(rx_out_valid),
		.rx_out_ready(rx_out_ready));

	link_partner partner (.ref_clk(ref_clk), .slow(slow),
		.tx_ready(tx_ready), .rx_clk(rx_clk), .rx_sym(rx_sym), .rx_k(rx_k));

	always #5 ref_clk = ~ref_clk;

	// Record every symbol taken, and count commas leaving the buffer
	always @(posedge ref_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			q.push_back({tx_no_scramble, tx_k, tx_sym});
		if (rx_out_valid === 1'b1 && rx_out_k === 1'b1
			&& rx_out_sym === SYM_COM)
			com_seen++;
	end

	task automatic report_and_stop;
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task automatic chk_word(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: word %h, want %h", $time, g, e);
		end
	endtask : chk_word

	task automatic chk_bit(input logic g, e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: flag %b, want %b", $time, g, e);
		end
	endtask : chk_bit

	task automatic chk_sym(input logic [9:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: symbol %h, want %h", $time, g, e);
		end
	endtask : chk_sym

	// Classic single cycle; waits for ack, never assumes a latency
	task automatic wb(input logic w, input logic [3:0] a, s,
		input logic [31:0] d);
		int t;
		t = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= d;
		do begin
			@(posedge ref_clk);
			t++;
		end while (ack !== 1'b1 && t < 20);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk_bit(ack, 1'b1);
	endtask : wb

	task automatic pop(output logic [9:0] v);
		int t;
		t = 0;
		while (q.size() == 0 && t < 500) begin
			@(posedge ref_clk);
			t++;
		end
		v = 10'h0;
		if (q.size() == 0)
			chk_bit(1'b0, 1'b1);
		else
			v = q.pop_front();
	endtask : pop

	// Skip pairs before a set are counted; an id of 0 takes TS1 or TS2
	task automatic expect_set(input logic [7:0] id, cfg, input int sk_exp,
		output logic [7:0] idv);
		logic [9:0] v;
		logic [9:0] e;
		int         sk;
		sk = 0;
		idv = id;
		pop(v);
		while (v[8:0] === {1'b1, SYM_SKP} && sk < 8) begin
			pop(v);
			chk_sym({1'b0, v[8:0]}, {2'b01, SYM_SKP});
			sk++;
			pop(v);
		end
		chk_word(sk, sk_exp);
		for (int j = 0; j < 16; j++) begin
			if (j > 0)
				pop(v);
			if (j == 6 && id == 8'h00)
				idv = v[7:0] === SYM_D5_2 ? SYM_D5_2 : SYM_D10_2;
			e = j < 4 ? {2'b11, SYM_COM}
				: {2'b10, j == 4 ? SYM_D0_0 : j == 5 ? cfg : idv};
			chk_sym(v, e);
		end
	endtask : expect_set

	task automatic pulse_polling;
		@(posedge ref_clk);
		polling_entry <= 1'b1;
		@(posedge ref_clk);
		polling_entry <= 1'b0;
	endtask : pulse_polling

	// A reset in mid-run must stop transmission and clear control
	task automatic mid_reset;
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_bit(tx_valid, 1'b0);
		q.delete();
		wb(1'b0, REG_CTRL, 4'hF, 32'h0);
		chk_word(rd, CTRL_RST);
	endtask : mid_reset

	task automatic rx_set(input logic [7:0] id, cfg);
		partner.send_set(id, cfg);
		repeat (12) @(posedge ref_clk);
	endtask : rx_set

	// Hang guard, sized well beyond the whole sequence
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (ROWS[i]) begin
			wb(ROWS[i].w, ROWS[i].a, ROWS[i].s, ROWS[i].d);
			if (!ROWS[i].w)
				chk_word(rd, ROWS[i].e);
		end
		$display("register rows done");
		// Config 0x0D asks for reset and loopback; only bits 2,3 may go out
		pulse_polling();
		wb(1'b1, REG_CTRL, 4'hF, 32'h0000_0D01);
		for (int i = 1; i <= 46; i++)
			expect_set(SYM_D10_2, 8'h0C, (i == 24 || i == 46), got);
		wb(1'b1, REG_CTRL, 4'hF, 32'h0000_0D03);
		got = SYM_D10_2;
		for (int i = 0; i < 6 && got !== SYM_D5_2; i++)
			expect_set(8'h00, 8'h0C, 0, got);
		chk_word({24'h0, got}, {24'h0, SYM_D5_2});
		expect_set(SYM_D5_2, 8'h0C, 0, got);
		$display("set and skip schedule done");
		mid_reset();
		pulse_polling();
		wb(1'b1, REG_CTRL, 4'hF, 32'h0000_0009);
		for (int i = 1; i <= 46; i++)
			expect_set(SYM_D10_2, 8'h00, i == 46 ? 2 : 0, got);
		$display("deferred skips done");
		mid_reset();
		pulse_polling();
		wb(1'b1, REG_CTRL, 4'hF, 32'h0000_0005);
		for (int r = 0; r < REPS * 32; r++) begin
			pop(v);
			chk_sym(v, r % 32 == 0 ? {2'b11, SYM_COM} : {2'b10,
				r % 32 < 16 ? TSQ[r % 32 - 1] : SYM_D10_2});
		end
		expect_set(SYM_D10_2, 8'h00, 0, got);
		wb(1'b0, REG_STATUS, 4'hF, 32'h0);
		chk_bit(rd[4], 1'b1);
		$display("equaliser sets done");
		rx_set(SYM_D10_2, 8'h0C);
		chk_bit(rx_loopback, 1'b1);
		chk_bit(rx_scr_disable, 1'b1);
		rx_set(SYM_D5_2, 8'h05);
		chk_bit(rx_loopback, 1'b1);
		chk_bit(rx_reset_req, 1'b0);
		rx_set(SYM_D10_2, 8'h00);
		chk_bit(rx_loopback, 1'b0);
		chk_bit(rx_invert, 1'b0);
		rx_set(SYM_D21_5, 8'h00);
		chk_bit(rx_invert, 1'b1);
		chk_bit(com_seen >= 4, 1'b1);
		$display("receive sets done");
		report_and_stop();
	end

endmodule : link_train_phy_tb

`default_nettype wire
